/* File: core/trcl_defs.svh */
// timing counts, digit layout and reset values for the trinary remote code link
// Function
// - encoder sends nine trinary digits serially
// - low send request starts a sequence
// - held request repeats; pulse gives two words
// - three idle data periods between words
// - digit is two short/long pulses by state
// - classify input by weak pull high, low
// - idle after second word stops the oscillator
// - start oscillator, probe inputs in turn, send
// - first five digits are the address
// - first matching word stores payload only
// - second matching equal payload loads outputs
// - flag high until mismatch or long silence
// - open payload digit decodes as one
// - address-only mode: nine digits, two matches
// - local code accepts three-state digits
// - narrow/wide threshold 1.72 encoder clocks
// - four silent data periods end transmission
// - two silent data periods restart word
`ifndef TRCL_DEFS_SVH
`define TRCL_DEFS_SVH

`define TRCL_CLK_PERIOD_NS 50
`define TRCL_ENC_PERIOD_NS 10000
`define TRCL_ENC_CYC (`TRCL_ENC_PERIOD_NS / `TRCL_CLK_PERIOD_NS)
`define TRCL_NUM_DIGITS 9
`define TRCL_ADDR_DIGITS 5
`define TRCL_PAY_BITS 4
`define TRCL_SHORT_HI 1
`define TRCL_LONG_HI 3
`define TRCL_DIGIT_TICKS 8
`define TRCL_GAP_PERIODS 3
`define TRCL_GAP_TICKS (`TRCL_GAP_PERIODS * `TRCL_DIGIT_TICKS)
`define TRCL_NARROW_X100 172
`define TRCL_NARROW_CYC ((`TRCL_NARROW_X100 * `TRCL_ENC_CYC + 99) / 100)
`define TRCL_EOT_X10 335
`define TRCL_EOT_CYC ((`TRCL_EOT_X10 * `TRCL_ENC_CYC) / 10)
`define TRCL_WGAP_X10 4
`define TRCL_CNT_W 16
`define TRCL_FIFO_DEPTH 8
`define TRCL_PAY_RST 4'h0

`endif

/* File: core/trcl_pkg.sv */
// types shared by the trinary remote code link
package trcl_pkg;
	typedef enum logic [1:0] {
		DIG_LOW = 2'b00,
		DIG_HIGH = 2'b01,
		DIG_OPEN = 2'b10,
		DIG_BAD = 2'b11
	} trcl_digit_type;

	typedef enum logic [1:0] {
		ENC_IDLE = 2'b00,
		ENC_PROBE = 2'b01,
		ENC_SEND = 2'b10,
		ENC_GAP = 2'b11
	} trcl_enc_state_type;
endpackage

/* File: core/trcl_fifo.sv */
// shift-register fifo for received payload words; head always sits in entry 0
`timescale 1ns/1ns
module trcl_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [CW-1:0] cnt_r, cnt_nxt, wr_pos;
	logic in_ready_r, out_valid_r, push, pop;

	always_comb begin
		push = in_valid && in_ready_r;
		pop = out_valid_r && out_ready;
		cnt_nxt = cnt_r + CW'(push) - CW'(pop);
		wr_pos = cnt_r - CW'(pop);
	end

	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_comb begin
			mem_nxt[i] = mem_r[i];
			if (pop && i < DEPTH - 1) begin
				mem_nxt[i] = mem_r[i + 1];
			end
			if (push && wr_pos == CW'(i)) begin
				mem_nxt[i] = in_data;
			end
		end
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_r[i] <= '0;
			end else begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	// flags are registered from the next count so both sides see honest state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			in_ready_r <= 1'b1;
			out_valid_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready_r <= cnt_nxt != CW'(DEPTH);
			out_valid_r <= cnt_nxt != '0;
		end
	end

	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data = mem_r[0];
endmodule // trcl_fifo

/* File: core/trcl_link.sv */
// trinary remote code link: encoder, decoder and received-word fifo
`timescale 1ns/1ns
`include "trcl_defs.svh"
module trcl_link #(
	parameter int EOT_CYC = `TRCL_EOT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// encoder request and code pins
	input wire logic send_request_n,
	input wire logic [8:0] code_pin_in,
	output logic [8:0] code_pull_out,
	output logic [8:0] code_pull_oe,
	// encoder serial line and oscillator status
	output logic ser_out,
	output logic enc_active,
	// decoder serial line and local code
	input wire logic ser_in,
	input wire trcl_pkg::trcl_digit_type [8:0] local_code_inputs,
	input wire logic addr_only_mode,
	// decoder results
	output logic valid_word_flag,
	output logic [3:0] payload_outputs,
	output logic word_overflow,
	// received word stream
	output logic word_out_valid,
	output logic [3:0] word_out_data,
	input wire logic word_out_ready,
	output logic word_fifo_ready
);
	import trcl_pkg::*;

	localparam int CNW = `TRCL_CNT_W;
	localparam int WGAP_CYC = (EOT_CYC * `TRCL_WGAP_X10) / 10;

	logic rst_s1_r, rst_n;

	// reset enters asynchronously but is released through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	// ---------------- encoder ----------------
	trcl_enc_state_type enc_st_r, enc_st_nxt;
	logic [CNW-1:0] div_r, div_nxt;
	logic [3:0] eidx_r, eidx_nxt;
	logic [2:0] tcnt_r, tcnt_nxt;
	logic [4:0] gcnt_r, gcnt_nxt;
	logic phase_r, phase_nxt, word_r, word_nxt, hi_read_r, hi_read_nxt;
	logic ser_out_r, ser_out_nxt, enc_active_r, enc_active_nxt;
	trcl_digit_type digits_r [9];
	trcl_digit_type digits_nxt [9];
	trcl_digit_type cur_dig;
	logic [8:0] pull_oe_r, pull_oe_nxt, pull_out_r, pull_out_nxt;
	logic tick, long_pulse;
	logic [1:0] hi_len;

	always_comb begin
		enc_st_nxt = enc_st_r;
		eidx_nxt = eidx_r;
		tcnt_nxt = tcnt_r;
		gcnt_nxt = gcnt_r;
		phase_nxt = phase_r;
		word_nxt = word_r;
		hi_read_nxt = hi_read_r;
		digits_nxt = digits_r;
		ser_out_nxt = 1'b0;
		// divider only runs outside idle, standing in for the stopped oscillator
		tick = (enc_st_r != ENC_IDLE) && (div_r == CNW'(`TRCL_ENC_CYC - 1));
		div_nxt = (enc_st_r == ENC_IDLE || tick) ? '0 : div_r + 1'b1;
		cur_dig = digits_r[eidx_r];
		long_pulse = (cur_dig == DIG_HIGH) || (cur_dig == DIG_OPEN && !tcnt_r[2]);
		hi_len = long_pulse ? 2'(`TRCL_LONG_HI) : 2'(`TRCL_SHORT_HI);
		case (enc_st_r)
			ENC_IDLE: begin
				if (!send_request_n) begin
					enc_st_nxt = ENC_PROBE;
					eidx_nxt = '0;
					phase_nxt = 1'b0;
					word_nxt = 1'b0;
				end
			end
			ENC_PROBE: begin
				if (!phase_r) begin
					hi_read_nxt = code_pin_in[eidx_r];
					phase_nxt = 1'b1;
				end else begin
					// pulled high and low both followed: the pin floats
					if (hi_read_r && !code_pin_in[eidx_r]) begin
						digits_nxt[eidx_r] = DIG_OPEN;
					end else if (hi_read_r) begin
						digits_nxt[eidx_r] = DIG_HIGH;
					end else begin
						digits_nxt[eidx_r] = DIG_LOW;
					end
					phase_nxt = 1'b0;
					if (eidx_r == 4'(`TRCL_NUM_DIGITS - 1)) begin
						enc_st_nxt = ENC_SEND;
						eidx_nxt = '0;
						tcnt_nxt = '0;
						div_nxt = '0;
					end else begin
						eidx_nxt = eidx_r + 1'b1;
					end
				end
			end
			ENC_SEND: begin
				ser_out_nxt = tcnt_r[1:0] < hi_len;
				if (tick) begin
					tcnt_nxt = tcnt_r + 1'b1;
					if (tcnt_r == 3'(`TRCL_DIGIT_TICKS - 1)) begin
						if (eidx_r == 4'(`TRCL_NUM_DIGITS - 1)) begin
							enc_st_nxt = ENC_GAP;
							gcnt_nxt = '0;
						end else begin
							eidx_nxt = eidx_r + 1'b1;
						end
					end
				end
			end
			ENC_GAP: begin
				if (tick) begin
					gcnt_nxt = gcnt_r + 1'b1;
					if (gcnt_r == 5'(`TRCL_GAP_TICKS - 1)) begin
						eidx_nxt = '0;
						tcnt_nxt = '0;
						if (!word_r) begin
							// second word repeats the probed digits
							enc_st_nxt = ENC_SEND;
							word_nxt = 1'b1;
						end else if (!send_request_n) begin
							enc_st_nxt = ENC_PROBE;
							word_nxt = 1'b0;
							phase_nxt = 1'b0;
						end else begin
							enc_st_nxt = ENC_IDLE;
						end
					end
				end
			end
			default: enc_st_nxt = ENC_IDLE;
		endcase
		enc_active_nxt = enc_st_nxt != ENC_IDLE;
	end

	for (genvar i = 0; i < `TRCL_NUM_DIGITS; i++) begin : g_pull
		always_comb begin
			pull_oe_nxt[i] = (enc_st_nxt == ENC_PROBE) && (eidx_nxt == 4'(i));
			pull_out_nxt[i] = pull_oe_nxt[i] && !phase_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enc_st_r <= ENC_IDLE;
			div_r <= '0;
			eidx_r <= '0;
			tcnt_r <= '0;
			gcnt_r <= '0;
			phase_r <= 1'b0;
			word_r <= 1'b0;
			hi_read_r <= 1'b0;
			ser_out_r <= 1'b0;
			enc_active_r <= 1'b0;
			digits_r <= '{default: DIG_LOW};
			pull_oe_r <= '0;
			pull_out_r <= '0;
		end else begin
			enc_st_r <= enc_st_nxt;
			div_r <= div_nxt;
			eidx_r <= eidx_nxt;
			tcnt_r <= tcnt_nxt;
			gcnt_r <= gcnt_nxt;
			phase_r <= phase_nxt;
			word_r <= word_nxt;
			hi_read_r <= hi_read_nxt;
			ser_out_r <= ser_out_nxt;
			enc_active_r <= enc_active_nxt;
			digits_r <= digits_nxt;
			pull_oe_r <= pull_oe_nxt;
			pull_out_r <= pull_out_nxt;
		end
	end

	// ---------------- decoder ----------------
	logic din_d_r, half_r, first_wide_r, word_ok_r, have_first_r, valid_r, push_r, ovf_r;
	logic din_d_nxt, half_nxt, first_wide_nxt, word_ok_nxt, have_first_nxt, valid_nxt, push_nxt, ovf_nxt;
	logic [CNW-1:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt;
	logic [3:0] didx_r, didx_nxt, acc_r, acc_nxt, stored_r, stored_nxt, pay_r, pay_nxt;
	logic [3:0] push_data_r, push_data_nxt;
	logic fall, wide, is_addr, dig_ok, ok_w, fifo_in_ready;
	trcl_digit_type rx_dig;
	logic [1:0] pidx;

	always_comb begin
		din_d_nxt = ser_in;
		half_nxt = half_r;
		first_wide_nxt = first_wide_r;
		word_ok_nxt = word_ok_r;
		have_first_nxt = have_first_r;
		valid_nxt = valid_r;
		didx_nxt = didx_r;
		acc_nxt = acc_r;
		stored_nxt = stored_r;
		pay_nxt = pay_r;
		push_nxt = 1'b0;
		push_data_nxt = push_data_r;
		ovf_nxt = ovf_r || (push_r && !fifo_in_ready);
		ok_w = 1'b0;
		pidx = 2'(didx_r - 4'(`TRCL_ADDR_DIGITS));
		fall = din_d_r && !ser_in;
		hi_cnt_nxt = ser_in ? ((&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 1'b1) : '0;
		lo_cnt_nxt = ser_in ? '0 : ((&lo_cnt_r) ? lo_cnt_r : lo_cnt_r + 1'b1);
		wide = hi_cnt_r >= CNW'(`TRCL_NARROW_CYC);
		case ({first_wide_r, wide})
			2'b00: rx_dig = DIG_LOW;
			2'b11: rx_dig = DIG_HIGH;
			2'b10: rx_dig = DIG_OPEN;
			default: rx_dig = DIG_BAD;
		endcase
		is_addr = addr_only_mode || didx_r < 4'(`TRCL_ADDR_DIGITS);
		// address digits compare in all three states
		dig_ok = (rx_dig != DIG_BAD) && (!is_addr || rx_dig == local_code_inputs[didx_r]);
		if (fall && didx_r < 4'(`TRCL_NUM_DIGITS)) begin
			if (!half_r) begin
				half_nxt = 1'b1;
				first_wide_nxt = wide;
			end else begin
				half_nxt = 1'b0;
				ok_w = word_ok_r && dig_ok;
				word_ok_nxt = ok_w;
				if (!is_addr) begin
					acc_nxt[pidx] = rx_dig != DIG_LOW;
				end
				didx_nxt = didx_r + 1'b1;
				if (didx_r == 4'(`TRCL_NUM_DIGITS - 1)) begin
					if (addr_only_mode) begin
						acc_nxt = '0;
					end
					if (!ok_w) begin
						valid_nxt = 1'b0;
						have_first_nxt = 1'b0;
					end else begin
						stored_nxt = acc_nxt;
						have_first_nxt = 1'b1;
						if (have_first_r && acc_nxt == stored_r) begin
							valid_nxt = 1'b1;
							pay_nxt = addr_only_mode ? pay_r : acc_nxt;
							push_nxt = 1'b1;
							push_data_nxt = acc_nxt;
						end else if (have_first_r) begin
							valid_nxt = 1'b0;
						end
					end
				end
			end
		end
		// dead time between words restarts collection
		if (!ser_in && lo_cnt_r == CNW'(WGAP_CYC - 1)) begin
			didx_nxt = '0;
			half_nxt = 1'b0;
			word_ok_nxt = 1'b1;
			acc_nxt = '0;
		end
		if (!ser_in && lo_cnt_r == CNW'(EOT_CYC - 1)) begin
			valid_nxt = 1'b0;
			have_first_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_d_r <= 1'b0;
			half_r <= 1'b0;
			first_wide_r <= 1'b0;
			word_ok_r <= 1'b1;
			have_first_r <= 1'b0;
			valid_r <= 1'b0;
			push_r <= 1'b0;
			ovf_r <= 1'b0;
			hi_cnt_r <= '0;
			lo_cnt_r <= '0;
			didx_r <= '0;
			acc_r <= '0;
			stored_r <= '0;
			pay_r <= `TRCL_PAY_RST;
			push_data_r <= '0;
		end else begin
			din_d_r <= din_d_nxt;
			half_r <= half_nxt;
			first_wide_r <= first_wide_nxt;
			word_ok_r <= word_ok_nxt;
			have_first_r <= have_first_nxt;
			valid_r <= valid_nxt;
			push_r <= push_nxt;
			ovf_r <= ovf_nxt;
			hi_cnt_r <= hi_cnt_nxt;
			lo_cnt_r <= lo_cnt_nxt;
			didx_r <= didx_nxt;
			acc_r <= acc_nxt;
			stored_r <= stored_nxt;
			pay_r <= pay_nxt;
			push_data_r <= push_data_nxt;
		end
	end

	// a word that finds the fifo full is dropped and flagged, since the wire cannot wait
	trcl_fifo #(
		.WIDTH(`TRCL_PAY_BITS),
		.DEPTH(`TRCL_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push_r),
		.in_data(push_data_r),
		.in_ready(fifo_in_ready),
		.out_valid(word_out_valid),
		.out_data(word_out_data),
		.out_ready(word_out_ready)
	);

	assign code_pull_out = pull_out_r;
	assign code_pull_oe = pull_oe_r;
	assign ser_out = ser_out_r;
	assign enc_active = enc_active_r;
	assign valid_word_flag = valid_r;
	assign payload_outputs = pay_r;
	assign word_overflow = ovf_r;
	assign word_fifo_ready = fifo_in_ready;
endmodule // trcl_link

/* File: sim/trcl_link_monitor.sv */
// port assertions for the trinary remote code link
`timescale 1ns/1ns
module trcl_link_monitor #(
	parameter int EOT_CYC = 6700
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// encoder side
	input wire logic send_request_n,
	input wire logic [8:0] code_pull_out,
	input wire logic [8:0] code_pull_oe,
	input wire logic ser_out,
	input wire logic enc_active,
	// decoder side
	input wire logic ser_in,
	input wire logic valid_word_flag,
	input wire logic [3:0] payload_outputs,
	input wire logic word_out_valid,
	input wire logic [3:0] word_out_data,
	input wire logic word_fifo_ready
);
	logic [15:0] hi_r, hi_nxt, lo_r, lo_nxt, sil_r, sil_nxt;
	// low run saturates while idle so the first pulse of a sequence never looks like a short gap
	always_comb begin
		hi_nxt = ser_out ? hi_r + 16'h0001 : 16'h0000;
		lo_nxt = !enc_active ? 16'hFFFF : (ser_out ? 16'h0000 : lo_r + {15'h0000, lo_r != 16'hFFFF});
		sil_nxt = ser_in ? 16'h0000 : sil_r + {15'h0000, sil_r != 16'hFFFF};
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_r <= 16'h0000;
			lo_r <= 16'hFFFF;
			sil_r <= 16'h0000;
		end else begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			sil_r <= sil_nxt;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_reset_clear: assert property (disable iff (1'b0)
		!rst_b |-> !valid_word_flag && payload_outputs == 4'h0 && !word_out_valid) else $error("reset outputs");
	chk_idle_quiet: assert property (!enc_active |-> !ser_out) else $error("pulse while idle");
	chk_start_osc: assert property (!enc_active && !send_request_n |=> enc_active) else $error("no start");
	chk_probe_first: assert property ($rose(enc_active) |-> code_pull_oe[0] && code_pull_out[0])
		else $error("probe start");
	chk_pulse_width: assert property ($fell(ser_out) |-> hi_r == 16'h00C8 || hi_r == 16'h0258)
		else $error("pulse width");
	chk_word_gap: assert property ($rose(ser_out) |-> lo_r == 16'h00C8 || lo_r == 16'h0258 || lo_r >= 16'h1388)
		else $error("low run length");
	chk_flag_push: assert property ($rose(valid_word_flag) && word_fifo_ready && !word_out_valid
		|-> ##2 word_out_valid && word_out_data == payload_outputs) else $error("word not queued");
	chk_flag_silence: assert property (valid_word_flag |-> sil_r <= EOT_CYC + 2) else $error("flag kept");
	chk_payload_hold: assert property ($changed(payload_outputs) |-> valid_word_flag)
		else $error("payload moved");
endmodule // trcl_link_monitor

/* File: sim/trcl_pin_model.sv */
// code pins strapped low, high or left open around the encoder
`timescale 1ns/1ns
module trcl_pin_model (
	// clock
	input wire logic clk,
	// straps: 0 low, 1 high, 2 open
	input wire logic [8:0][1:0] pin_mode,
	// weak drive from the encoder
	input wire logic [8:0] pull_out,
	input wire logic [8:0] pull_oe,
	// resolved pin level
	output logic [8:0] pin_level
);
	logic [8:0] last_r;
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			if (pin_mode[i] == 2'h0) begin
				pin_level[i] = 1'b0;
			end else if (pin_mode[i] == 2'h1) begin
				pin_level[i] = 1'b1;
			end else begin
				// an undriven open pin drifts, so a probe that samples late reads garbage
				pin_level[i] = pull_oe[i] ? pull_out[i] : ~last_r[i];
			end
		end
	end
	always_ff @(posedge clk) begin
		last_r <= pin_level;
	end
endmodule // trcl_pin_model

/* File: sim/tb.sv */
// loopback testbench for the trinary remote code link
`timescale 1ns/1ns
module tb;
	import trcl_pkg::*;
	localparam logic [17:0] CODE = 18'h19124;
	logic clk, rst_b, send_request_n, addr_only_mode, word_out_ready;
	logic [8:0] code_pin_in, code_pull_out, code_pull_oe;
	logic ser_out, enc_active, valid_word_flag, word_overflow, word_out_valid, word_fifo_ready;
	logic [3:0] payload_outputs, word_out_data;
	trcl_digit_type [8:0] local_code_inputs;
	wire ser_in = ser_out;
	int failures, cmp_count;

	trcl_pin_model pins (.clk(clk), .pin_mode(CODE), .pull_out(code_pull_out), .pull_oe(code_pull_oe),
		.pin_level(code_pin_in));
	trcl_link dut (.clk(clk), .rst_b(rst_b), .send_request_n(send_request_n), .code_pin_in(code_pin_in),
		.code_pull_out(code_pull_out), .code_pull_oe(code_pull_oe), .ser_out(ser_out), .enc_active(enc_active),
		.ser_in(ser_in), .local_code_inputs(local_code_inputs), .addr_only_mode(addr_only_mode),
		.valid_word_flag(valid_word_flag), .payload_outputs(payload_outputs), .word_overflow(word_overflow),
		.word_out_valid(word_out_valid), .word_out_data(word_out_data), .word_out_ready(word_out_ready),
		.word_fifo_ready(word_fifo_ready));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t nibble got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic set_local(input logic [17:0] v);
		for (int i = 0; i < 9; i++) begin
			local_code_inputs[i] <= trcl_digit_type'(v[2*i+:2]);
		end
	endtask

	// sel 0 watches the flag, sel 1 the encoder activity
	task automatic wait_on(input int sel, input logic lvl, input int lim);
		int n;
		n = 0;
		while ((sel == 0 ? valid_word_flag : enc_active) !== lvl) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				failures++;
				$display("[ERR] %0t wait timed out", $time);
				give_verdict();
			end
		end
	endtask

	// one-cycle request still has to give a full two-word sequence
	task automatic pulse_request();
		@(posedge clk);
		send_request_n <= 1'b0;
		@(posedge clk);
		send_request_n <= 1'b1;
		#1;
	endtask

	task automatic sc_reset();
		chk1(valid_word_flag, 1'b0);
		chk4(payload_outputs, 4'h0);
		chk1(word_out_valid, 1'b0);
		chk1(enc_active, 1'b0);
		chk1(word_fifo_ready, 1'b1);
		chk1(word_overflow, 1'b0);
	endtask

	task automatic sc_pair();
		pulse_request();
		wait_on(1, 1'b1, 4);
		// inside the gap after the first word: payload only stored, nothing shown yet
		repeat (17000) @(posedge clk);
		#1;
		chk1(valid_word_flag, 1'b0);
		chk4(payload_outputs, 4'h0);
		wait_on(0, 1'b1, 40000);
		chk4(payload_outputs, 4'hE);
		repeat (2) @(posedge clk);
		#1;
		chk1(word_out_valid, 1'b1);
		chk4(word_out_data, 4'hE);
		chk1(word_overflow, 1'b0);
		wait_on(1, 1'b0, 10000);
		chk1(valid_word_flag, 1'b1);
		wait_on(0, 1'b0, 3000);
		@(posedge clk);
		word_out_ready <= 1'b1;
		@(posedge clk);
		word_out_ready <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk1(word_out_valid, 1'b0);
	endtask

	task automatic sc_addr_only();
		int n;
		int seen;
		n = 0;
		seen = 0;
		@(posedge clk);
		set_local(18'h09124);
		addr_only_mode <= 1'b1;
		pulse_request();
		while (enc_active === 1'b1 && n < 45000) begin
			@(posedge clk);
			#1;
			n++;
			if (valid_word_flag !== 1'b0) begin
				seen++;
			end
		end
		chk1(enc_active, 1'b0);
		chk1(seen != 0, 1'b0);
		chk4(payload_outputs, 4'hE);
		chk1(word_out_valid, 1'b0);
	endtask

	// reset in mid-run must drop the payload latched by the earlier sequence
	task automatic sc_reset_mid();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk4(payload_outputs, 4'h0);
		chk1(valid_word_flag, 1'b0);
		@(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk4(payload_outputs, 4'h0);
		chk1(word_out_valid, 1'b0);
		chk1(enc_active, 1'b0);
	endtask

	initial begin
		failures = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		send_request_n = 1'b1;
		addr_only_mode = 1'b0;
		word_out_ready = 1'b0;
		set_local(CODE);
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		sc_reset();
		sc_pair();
		sc_addr_only();
		sc_reset_mid();
		give_verdict();
	end
endmodule // tb

bind trcl_link trcl_link_monitor #(.EOT_CYC(EOT_CYC)) mon (.clk(clk), .rst_b(rst_b),
	.send_request_n(send_request_n), .code_pull_out(code_pull_out), .code_pull_oe(code_pull_oe),
	.ser_out(ser_out), .enc_active(enc_active), .ser_in(ser_in), .valid_word_flag(valid_word_flag),
	.payload_outputs(payload_outputs), .word_out_valid(word_out_valid), .word_out_data(word_out_data),
	.word_fifo_ready(word_fifo_ready));
